/* File: design/wpim_regs.sv */
// wake pin mode and interrupt mask registers behind the serial command port
//
// What this block does
// - The pin mode register holds a two-bit field per pin: pin 3 in 7:6, pin 2 in 5:4, pin 1 in 3:2, pin 0 in 1:0.
// - Mode 00 keeps the pin driver off and ignores pin transitions as wake sources.
// - Mode 01 keeps the pin driver off and accepts pin transitions as wake sources.
// - Pins 3 and 2 turn on their high-side driver for mode 10 or 11.
// - Pins 1 and 0 turn on the low-side driver for mode 10 and the high-side driver for mode 11.
// - Mask bit 7 passes CAN bus faults to the interrupt output.
// - Enabling the host request gives exactly one interrupt, not a repeated one.
// - The host request fires only when mask bits 6 and 2 are both 1, and the host sets both.
// - Mask bit 5 passes second LIN failures to the interrupt output, and 0 suppresses them.
// - Mask bit 4 passes first LIN failures to the interrupt output, and 0 suppresses them.
// - Mask bit 3 passes wake pin failures to the interrupt output, and 0 suppresses them.
// - Mask bit 2 passes regulator overvoltage, pre-warning, undervoltage, safety and host request events.
// - Mask bit 0 passes regulator monitoring events to the interrupt output.
`timescale 1ns/1ps
`default_nettype none

module wpim_regs (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic spi_cs_b_in,
	input wire logic spi_sclk_in,
	input wire logic spi_mosi_in,
	output logic spi_miso_out,
	output logic spi_miso_oe_out,
	input wire logic [3:0] wake_pin_level_in,
	input wire wpim_pkg::wpim_fault_s fault_in,
	output wpim_pkg::wpim_pin_drive_s pin_drive_out,
	output logic wake_event_out,
	output logic int_req_out
);

	// decode one pin's mode into its high-side enable
	function automatic logic high_on(input logic [1:0] mode, input logic low_capable);
		if (low_capable) begin
			high_on = (mode == wpim_pkg::MODE_HIGH);
		end else begin
			high_on = (mode == wpim_pkg::MODE_LOW_OR_HIGH) || (mode == wpim_pkg::MODE_HIGH);
		end
	endfunction

	// read back of the register at an address, zero for anything unmapped
	function automatic logic [7:0] read_reg(input logic [4:0] addr, input logic [7:0] cfg,
			input logic [7:0] mask);
		if (addr == wpim_pkg::ADDR_WAKE_PIN_MODE_CONFIG) begin
			read_reg = cfg;
		end else if (addr == wpim_pkg::ADDR_INTERRUPT_ENABLE_MASK) begin
			read_reg = mask;
		end else begin
			read_reg = 8'h00;
		end
	endfunction

	wpim_pkg::wpim_state_e state_ff, nxt_state;
	logic sclk_ff, nxt_sclk;
	logic cs_b_ff, nxt_cs_b;
	logic [4:0] bit_cnt_ff, nxt_bit_cnt;
	logic [15:0] rx_ff, nxt_rx;
	logic [7:0] tx_ff, nxt_tx;
	logic miso_ff, nxt_miso;
	logic miso_oe_ff, nxt_miso_oe;
	logic [7:0] wake_pin_mode_config_ff, nxt_wake_pin_mode_config;
	logic [7:0] interrupt_enable_mask_ff, nxt_interrupt_enable_mask;
	logic sclk_rise, sclk_fall, frame_end;
	logic [15:0] rx_shifted;

	// inputs are synchronous, so one stage of history suffices for edge detection
	assign sclk_rise = spi_sclk_in && !sclk_ff && !spi_cs_b_in;
	assign sclk_fall = !spi_sclk_in && sclk_ff && !spi_cs_b_in;
	assign frame_end = spi_cs_b_in && !cs_b_ff;
	assign rx_shifted = {rx_ff[14:0], spi_mosi_in};

	// serial frame engine and register writes
	always_comb begin
		nxt_state = state_ff;
		nxt_sclk = spi_sclk_in;
		nxt_cs_b = spi_cs_b_in;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_rx = rx_ff;
		nxt_tx = tx_ff;
		nxt_miso = miso_ff;
		nxt_miso_oe = !spi_cs_b_in;
		nxt_wake_pin_mode_config = wake_pin_mode_config_ff;
		nxt_interrupt_enable_mask = interrupt_enable_mask_ff;
		case (state_ff)
			wpim_pkg::ST_IDLE: begin
				nxt_bit_cnt = 5'h00;
				nxt_miso = 1'b0;
				if (!spi_cs_b_in) begin
					nxt_state = wpim_pkg::ST_SHIFT;
				end
			end
			wpim_pkg::ST_SHIFT: begin
				if (frame_end) begin
					// a frame of the wrong length is dropped whole, so a glitch never writes
					if (bit_cnt_ff == wpim_pkg::FRAME_BITS &&
							rx_ff[wpim_pkg::CMD_MSB:wpim_pkg::CMD_LSB] == wpim_pkg::CMD_WRITE) begin
						if (rx_ff[wpim_pkg::ADDR_MSB:wpim_pkg::ADDR_LSB] ==
								wpim_pkg::ADDR_WAKE_PIN_MODE_CONFIG) begin
							nxt_wake_pin_mode_config = rx_ff[7:0];
						end
						if (rx_ff[wpim_pkg::ADDR_MSB:wpim_pkg::ADDR_LSB] ==
								wpim_pkg::ADDR_INTERRUPT_ENABLE_MASK) begin
							nxt_interrupt_enable_mask = rx_ff[7:0];
						end
					end
					nxt_state = wpim_pkg::ST_IDLE;
				end else if (sclk_rise) begin
					nxt_rx = rx_shifted;
					// saturate so an over-long frame stays recognisably wrong
					if (bit_cnt_ff != 5'h1F) begin
						nxt_bit_cnt = bit_cnt_ff + 5'h01;
					end
					// header complete: load the addressed register for a read
					if (bit_cnt_ff + 5'h01 == wpim_pkg::HEADER_BITS) begin
						if (rx_shifted[7:6] == wpim_pkg::CMD_READ) begin
							nxt_tx = read_reg(rx_shifted[5:1], wake_pin_mode_config_ff,
								interrupt_enable_mask_ff);
						end else begin
							nxt_tx = 8'h00;
						end
						nxt_miso = nxt_tx[7];
					end
				end else if (sclk_fall) begin
					if (bit_cnt_ff > wpim_pkg::HEADER_BITS && bit_cnt_ff < wpim_pkg::FRAME_BITS) begin
						nxt_tx = {tx_ff[6:0], 1'b0};
						nxt_miso = tx_ff[6];
					end
				end
			end
			default: begin
				nxt_state = wpim_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_ff <= wpim_pkg::ST_IDLE;
			sclk_ff <= 1'b0;
			cs_b_ff <= 1'b1;
			bit_cnt_ff <= 5'h00;
			rx_ff <= 16'h0000;
			tx_ff <= 8'h00;
			miso_ff <= 1'b0;
			miso_oe_ff <= 1'b0;
			wake_pin_mode_config_ff <= wpim_pkg::RST_WAKE_PIN_MODE_CONFIG;
			interrupt_enable_mask_ff <= wpim_pkg::RST_INTERRUPT_ENABLE_MASK;
		end else begin
			state_ff <= nxt_state;
			sclk_ff <= nxt_sclk;
			cs_b_ff <= nxt_cs_b;
			bit_cnt_ff <= nxt_bit_cnt;
			rx_ff <= nxt_rx;
			tx_ff <= nxt_tx;
			miso_ff <= nxt_miso;
			miso_oe_ff <= nxt_miso_oe;
			wake_pin_mode_config_ff <= nxt_wake_pin_mode_config;
			interrupt_enable_mask_ff <= nxt_interrupt_enable_mask;
		end
	end

	assign spi_miso_out = miso_ff;
	assign spi_miso_oe_out = miso_oe_ff;

	wpim_pkg::wpim_pin_drive_s drive_ff, nxt_drive;
	logic [3:0] pin_level_ff, nxt_pin_level;
	logic wake_event_ff, nxt_wake_event;

	// pin drivers follow the mode fields; wake transitions count only in wake mode
	always_comb begin
		logic [1:0] mode;
		mode = 2'h0;
		nxt_drive = '0;
		nxt_pin_level = wake_pin_level_in;
		nxt_wake_event = 1'b0;
		for (int i = 0; i < wpim_pkg::PIN_COUNT; i++) begin
			mode = wake_pin_mode_config_ff[i*wpim_pkg::MODE_WIDTH +: wpim_pkg::MODE_WIDTH];
			// modes 00 and 01 leave both drivers off
			nxt_drive.high_side_driver[i] = high_on(mode, wpim_pkg::LOW_SIDE_CAPABLE[i]);
			nxt_drive.low_side_driver[i] = wpim_pkg::LOW_SIDE_CAPABLE[i] &&
				(mode == wpim_pkg::MODE_LOW_OR_HIGH);
			nxt_drive.wake_enable[i] = (mode == wpim_pkg::MODE_WAKE);
			if (nxt_drive.wake_enable[i] && (wake_pin_level_in[i] != pin_level_ff[i])) begin
				nxt_wake_event = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			drive_ff <= '0;
			pin_level_ff <= 4'h0;
			wake_event_ff <= 1'b0;
		end else begin
			drive_ff <= nxt_drive;
			pin_level_ff <= nxt_pin_level;
			wake_event_ff <= nxt_wake_event;
		end
	end

	assign pin_drive_out = drive_ff;
	assign wake_event_out = wake_event_ff;

	logic req_armed_ff, nxt_req_armed;
	logic int_ff, nxt_int;
	logic host_req_rise;

	// host request fires once on the write that first makes both bits set
	assign host_req_rise = nxt_req_armed && !req_armed_ff;

	// each fault source gated by its own mask bit, the host request by bits 6 and 2 together; bit 1 is never looked at
	always_comb begin
		nxt_req_armed = interrupt_enable_mask_ff[wpim_pkg::MASK_HOST_REQUEST] &&
			interrupt_enable_mask_ff[wpim_pkg::MASK_SAFETY];
		nxt_int = (fault_in.can_fault && interrupt_enable_mask_ff[wpim_pkg::MASK_CAN_FAULT])
			|| (fault_in.second_lin_fault && interrupt_enable_mask_ff[wpim_pkg::MASK_SECOND_LIN])
			|| (fault_in.first_lin_fault && interrupt_enable_mask_ff[wpim_pkg::MASK_FIRST_LIN])
			|| (fault_in.wake_pin_fault && interrupt_enable_mask_ff[wpim_pkg::MASK_WAKE_PIN])
			|| (fault_in.safety_event && interrupt_enable_mask_ff[wpim_pkg::MASK_SAFETY])
			|| (fault_in.vmon_event && interrupt_enable_mask_ff[wpim_pkg::MASK_VMON])
			|| host_req_rise;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			req_armed_ff <= 1'b0;
			int_ff <= 1'b0;
		end else begin
			req_armed_ff <= nxt_req_armed;
			int_ff <= nxt_int;
		end
	end

	assign int_req_out = int_ff;

endmodule

`default_nettype wire

/* File: inc/wpim_pkg.sv */
// constants and carrier types for the wake pin and interrupt mask register bank
package wpim_pkg;
	// serial frame layout: [15:14] command, [13:9] address, [8] parity, [7:0] data
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] HEADER_BITS = 5'h08;
	localparam int CMD_MSB = 15;
	localparam int CMD_LSB = 14;
	localparam int ADDR_MSB = 13;
	localparam int ADDR_LSB = 9;
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;

	// register addresses
	localparam logic [4:0] ADDR_WAKE_PIN_MODE_CONFIG = 5'h11;
	localparam logic [4:0] ADDR_INTERRUPT_ENABLE_MASK = 5'h12;

	// values after reset
	localparam logic [7:0] RST_WAKE_PIN_MODE_CONFIG = 8'h00;
	localparam logic [7:0] RST_INTERRUPT_ENABLE_MASK = 8'h00;

	// mode field of each wake pin: pin n sits in bits 2n+1:2n
	localparam int PIN_COUNT = 4;
	localparam int MODE_WIDTH = 2;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_WAKE = 2'h1;
	localparam logic [1:0] MODE_LOW_OR_HIGH = 2'h2;
	localparam logic [1:0] MODE_HIGH = 2'h3;
	// pins 3 and 2 only have a high-side driver, pins 1 and 0 have both
	localparam logic [3:0] LOW_SIDE_CAPABLE = 4'h3;

	// interrupt mask bit positions
	localparam int MASK_CAN_FAULT = 7;
	localparam int MASK_HOST_REQUEST = 6;
	localparam int MASK_SECOND_LIN = 5;
	localparam int MASK_FIRST_LIN = 4;
	localparam int MASK_WAKE_PIN = 3;
	localparam int MASK_SAFETY = 2;
	localparam int MASK_UNUSED = 1;
	localparam int MASK_VMON = 0;

	// fault and request events from the detectors, one-cycle pulses
	typedef struct packed {
		logic can_fault;
		logic second_lin_fault;
		logic first_lin_fault;
		logic wake_pin_fault;
		logic safety_event;
		logic vmon_event;
	} wpim_fault_s;

	// drive controls for the four wake pins
	typedef struct packed {
		logic [3:0] high_side_driver;
		logic [3:0] low_side_driver;
		logic [3:0] wake_enable;
	} wpim_pin_drive_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SHIFT = 2'b10
	} wpim_state_e;
endpackage

/* File: test/wpim_regs_monitor.sv */
// assertion checker for the wake pin and interrupt mask register bank
`timescale 1ns/1ps
`default_nettype none
module wpim_regs_monitor (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic spi_cs_b_in,
	input wire logic spi_sclk_in,
	input wire logic spi_mosi_in,
	input wire logic spi_miso_out,
	input wire logic spi_miso_oe_out,
	input wire logic [3:0] wake_pin_level_in,
	input wire wpim_pkg::wpim_fault_s fault_in,
	input wire wpim_pkg::wpim_pin_drive_s pin_drive_out,
	input wire logic wake_event_out,
	input wire logic int_req_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// pins 3 and 2 have no low-side stage at all
	a_no_low_upper: assert property (pin_drive_out.low_side_driver[3:2] == 2'h0)
		else $error("low-side driver on an upper pin");
	// a driving pin is never a wake input, and never drives both ways
	a_drive_exclusive: assert property ((pin_drive_out.high_side_driver & pin_drive_out.low_side_driver) == 4'h0 && ((pin_drive_out.high_side_driver | pin_drive_out.low_side_driver) & pin_drive_out.wake_enable) == 4'h0)
		else $error("pin drive fields overlap");
	// besides a fault, only a frame that ended two edges back may raise the interrupt
	a_int_cause: assert property (int_req_out |-> $past(fault_in) != 6'h00 || ($past(spi_cs_b_in, 2) && !$past(spi_cs_b_in, 3)))
		else $error("interrupt without a cause");
	a_host_once: assert property (int_req_out && $past(fault_in) == 6'h00 |=> !int_req_out || $past(fault_in) != 6'h00)
		else $error("host request interrupt repeated");
	// a pin that moved between the two edges before the pulse must be in wake mode
	a_wake_cause: assert property (wake_event_out |-> (pin_drive_out.wake_enable & ($past(wake_pin_level_in, 1) ^ $past(wake_pin_level_in, 2))) != 4'h0)
		else $error("wake event from a pin not in wake mode");
	// drive outputs move only as the result of a finished frame
	a_drive_timing: assert property (!$stable(pin_drive_out) |-> $past(spi_cs_b_in, 2) && !$past(spi_cs_b_in, 3))
		else $error("pin drive changed outside a write");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_b_in |-> pin_drive_out == 12'h000 && !int_req_out && !wake_event_out)
		else $error("outputs active during reset");
	a_oe_follow: assert property (spi_miso_oe_out == !$past(spi_cs_b_in))
		else $error("serial output enable not following frame select");
endmodule
bind wpim_regs wpim_regs_monitor u_mon (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.spi_cs_b_in(spi_cs_b_in), .spi_sclk_in(spi_sclk_in), .spi_mosi_in(spi_mosi_in),
	.spi_miso_out(spi_miso_out), .spi_miso_oe_out(spi_miso_oe_out),
	.wake_pin_level_in(wake_pin_level_in), .fault_in(fault_in), .pin_drive_out(pin_drive_out),
	.wake_event_out(wake_event_out), .int_req_out(int_req_out));
`default_nettype wire

/* File: test/wpim_host_model.sv */
// serial host model that frames commands into the register bank
`timescale 1ns/1ps
`default_nettype none
module wpim_host_model (
	input wire logic clk_in,
	input wire logic miso_in,
	output logic cs_b_out,
	output logic sclk_out,
	output logic mosi_out
);
	// serial clock stands low between frames
	initial begin
		cs_b_out = 1'b1;
		sclk_out = 1'b0;
		mosi_out = 1'b0;
	end
	// one 16-bit frame, msb first; two cycles per phase so the sampler sees each level
	task automatic xfer(input logic [1:0] cmd, input logic [4:0] addr, input logic [7:0] data,
			output logic [7:0] rd);
		logic [15:0] f;
		f = {cmd, addr, 1'b0, data};
		rd = 8'h00;
		@(posedge clk_in);
		#1 cs_b_out = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_out = f[i];
			repeat (2) @(posedge clk_in);
			#1 if (i < 8) rd = {rd[6:0], miso_in};
			sclk_out = 1'b1;
			repeat (2) @(posedge clk_in);
			#1 sclk_out = 1'b0;
		end
		repeat (2) @(posedge clk_in);
		#1 cs_b_out = 1'b1;
		mosi_out = ~mosi_out; // released line must not keep showing the last bit
		repeat (3) @(posedge clk_in);
		#1;
	endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the wake pin and interrupt mask register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_in, rst_b_in, cs_b, sclk, mosi, miso, miso_oe, wake_ev, int_req;
	logic [3:0] level;
	logic [7:0] rd;
	wire logic miso_w;
	wpim_pkg::wpim_fault_s fault;
	wpim_pkg::wpim_pin_drive_s drive;
	int failures = 0, cmp_count = 0, irq_cnt = 0, wake_cnt = 0;
	int pos [6] = '{0, 2, 3, 4, 5, 7};
	assign miso_w = miso_oe ? miso : 1'bz;
	wpim_regs DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .spi_cs_b_in(cs_b), .spi_sclk_in(sclk),
		.spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe), .wake_pin_level_in(level),
		.fault_in(fault), .pin_drive_out(drive), .wake_event_out(wake_ev), .int_req_out(int_req));
	wpim_host_model host (.clk_in(clk_in), .miso_in(miso_w), .cs_b_out(cs_b), .sclk_out(sclk),
		.mosi_out(mosi));
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// pulses are counted, so a long or repeated pulse shows as a wrong count
	always @(posedge clk_in) begin
		if (int_req === 1'b1) irq_cnt++;
		if (wake_ev === 1'b1) wake_cnt++;
	end
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask
	task automatic rdchk(input string what, input logic [4:0] a, input logic [7:0] exp);
		host.xfer(wpim_pkg::CMD_READ, a, 8'h00, rd);
		chk(what, {8'h00, exp}, {8'h00, rd});
	endtask
	// mask write, then count the interrupt pulses it causes
	task automatic wr_irq(input logic [7:0] d, input int exp);
		int base;
		base = irq_cnt;
		host.xfer(wpim_pkg::CMD_WRITE, wpim_pkg::ADDR_INTERRUPT_ENABLE_MASK, d, rd);
		repeat (2) @(posedge clk_in);
		#1 chk("mask write irq", 16'(exp), 16'(irq_cnt - base));
	endtask
	task automatic pulse(input logic [5:0] f, input int exp);
		int base;
		base = irq_cnt;
		fault = f;
		@(posedge clk_in);
		#1 fault = 6'h00;
		repeat (3) @(posedge clk_in);
		#1 chk("fault irq", 16'(exp), 16'(irq_cnt - base));
	endtask
	initial begin
		repeat (20000) @(posedge clk_in);
		failures++;
		end_of_test();
	end
	initial begin
		logic [1:0] m;
		int base;
		rst_b_in = 1'b0;
		level = 4'h0;
		fault = 6'h00;
		repeat (2) @(posedge clk_in);
		#1 rst_b_in = 1'b1;
		repeat (2) @(posedge clk_in);
		rdchk("mode reset", wpim_pkg::ADDR_WAKE_PIN_MODE_CONFIG, 8'h00);
		rdchk("mask reset", wpim_pkg::ADDR_INTERRUPT_ENABLE_MASK, 8'h00);
		// each mode on all pins, then every pin level flips once
		for (int k = 0; k < 4; k++) begin
			m = 2'(k);
			host.xfer(wpim_pkg::CMD_WRITE, wpim_pkg::ADDR_WAKE_PIN_MODE_CONFIG, {4{m}}, rd);
			chk("pin drive", {4'h0, {2{m[1]}}, {2{m == 2'h3}}, 2'h0, {2{m == 2'h2}}, {4{m == 2'h1}}}, {4'h0, drive});
			base = wake_cnt;
			level = ~level;
			repeat (4) @(posedge clk_in);
			#1 chk("wake events", 16'(m == 2'h1), 16'(wake_cnt - base));
			rdchk("mode readback", wpim_pkg::ADDR_WAKE_PIN_MODE_CONFIG, {4{m}});
		end
		// unmapped address and unknown command change nothing
		host.xfer(wpim_pkg::CMD_WRITE, 5'h13, 8'h5A, rd);
		rdchk("unmapped", 5'h13, 8'h00);
		rdchk("mask kept", wpim_pkg::ADDR_INTERRUPT_ENABLE_MASK, 8'h00);
		host.xfer(2'h2, wpim_pkg::ADDR_WAKE_PIN_MODE_CONFIG, 8'h00, rd);
		chk("bad command data", 16'h0000, {8'h00, rd});
		rdchk("bad command", wpim_pkg::ADDR_WAKE_PIN_MODE_CONFIG, 8'hFF);
		wr_irq(8'h40, 0);
		wr_irq(8'h44, 1);
		wr_irq(8'h44, 0);
		wr_irq(8'h04, 0);
		wr_irq(8'h44, 1);
		// each source alone enabled, then all but it (host request kept off)
		for (int j = 0; j < 6; j++) begin
			wr_irq(8'h01 << pos[j], 0);
			pulse(6'h01 << j, 1);
			wr_irq(~(8'h01 << pos[j]) & 8'hBF, 0);
			pulse(6'h01 << j, 0);
		end
		wr_irq(8'h02, 0);
		pulse(6'h3F, 0);
		end_of_test();
	end
endmodule
`default_nettype wire
